// ===== design/cspf_top.v
// Summary of operation
// R01: processor clock runs at standard 4.77 MHz or high 10 MHz.
// R02: standard rate memory access lasts four processor cycles.
// R03: standard rate I/O access lasts five processor cycles.
// R04: high rate on-board RAM access lasts four fast cycles.
// R05: in high speed, I/O accesses drop to standard rate, five cycles.
// R06: in high speed, DMA cycles also run at standard rate.
// R07: high-speed lamp lit exactly while running in high-speed mode. Here it follows speed_reg, so it stays lit through I/O and DMA stretches.
// R08: two-digit display shows 5 at standard, 10 at high rate.
// R09: keyboard lock engaged discards all keystroke data.
// R10: security lock left unlocks and enables reset; right locks both.
// R11: unlocked reset button press applies system hardware reset.
// R12: extra lamp follows the disk controller activity signal.
// R13: speed register bit 7 selects rate, other bits unused.
// R14: rate changes only at cycle boundaries; stretch ends with access.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cspf_map.vh"

module cspf_top #(
   parameter HAS_SEC_LOCK = 1
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        bus_start,
   input  wire [1:0]  bus_kind,
   output reg         bus_busy,
   output reg         bus_done,
   output reg         cpu_tick,
   output reg         cpu_fast,
   input  wire        kb_valid,
   input  wire [7:0]  kb_data,
   output reg         kb_out_valid,
   output reg  [7:0]  kb_out_data,
   input  wire        kb_lock_pin,
   input  wire        sec_lock_right_pin,
   input  wire        reset_btn_pin,
   input  wire        hdd_act_pin,
   output reg         sys_reset,
   output reg         speed_lamp,
   output reg         hdd_lamp,
   output reg  [6:0]  seg_tens,
   output reg  [6:0]  seg_units
);

   // ------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------
   reg [3:0] pin_s1_reg;
   reg [3:0] pin_s2_reg;

   // first stage is read only by the second
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_reg <= 4'h0;
         pin_s2_reg <= 4'h0;
      end else begin
         pin_s1_reg <= {hdd_act_pin, reset_btn_pin,
                        sec_lock_right_pin, kb_lock_pin};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   wire kb_lock_s   = pin_s2_reg[0];
   wire sec_right_s = pin_s2_reg[1];
   wire rst_btn_s   = pin_s2_reg[2];
   wire hdd_act_s   = pin_s2_reg[3];

   // ------------------------------------------------
   // lock decode
   // ------------------------------------------------
   // the plain keyboard lock always works; the combined lock adds to it,
   // so a panel wired with both cannot leave the keyboard open by mistake
   wire kb_locked  = kb_lock_s ||                                   // R09
                     ((HAS_SEC_LOCK != 0) && sec_right_s);          // R10
   wire rst_locked = (HAS_SEC_LOCK != 0) && sec_right_s;            // R10

   // ------------------------------------------------
   // address decode
   // ------------------------------------------------
   // only whole words are decoded, byte offsets inside a word are ignored
   localparam [11:0] SPEED_A    = `CSPF_SPEED_ADDR;
   localparam [11:0] STATUS_A   = `CSPF_STATUS_ADDR;
   localparam [9:0]  SPEED_IDX  = SPEED_A[11:2];
   localparam [9:0]  STATUS_IDX = STATUS_A[11:2];

   // ------------------------------------------------
   // register state
   // ------------------------------------------------
   reg         speed_reg;
   reg         aw_full_reg;
   reg [11:0]  aw_addr_reg;
   reg         w_full_reg;
   reg [31:0]  w_data_reg;
   reg [3:0]   w_strb_reg;

   // ------------------------------------------------
   // access sequencer state
   // ------------------------------------------------
   reg [1:0]   kind_reg;
   reg [2:0]   tcnt_reg;
   reg [13:0]  acc_reg;
   reg         stretch;
   reg [2:0]   need_cyc;
   reg         rate_ok;
   reg         tick_now;
   reg [14:0]  acc_sum;
   reg [14:0]  acc_left;

   // standard rate is made by a phase accumulator, so the
   // ticks jitter by one aclk but average 4.77 MHz
   always @* begin
      acc_sum  = {1'b0, acc_reg} + `CSPF_STD_KHZ;
      acc_left = acc_sum - `CSPF_CLK_KHZ;
      if (cpu_fast)
         tick_now = 1'b1;                                 // R01
      else
         tick_now = (acc_sum >= `CSPF_CLK_KHZ);           // R01
   end

   // I/O and DMA force the standard rate while active
   always @* begin
      stretch = bus_busy && (kind_reg != `CSPF_K_MEM);    // R05 R06
      case (kind_reg)
         `CSPF_K_IO:  need_cyc = `CSPF_IO_CYC;             // R03 R05
         `CSPF_K_DMA: need_cyc = `CSPF_DMA_CYC;            // R06
         default:     need_cyc = `CSPF_MEM_CYC;            // R02 R04
      endcase
      // a cycle counts only once the rate has settled
      rate_ok = stretch ? !cpu_fast : (cpu_fast == speed_reg);
   end

   // processor clock ticks and rate switch
   always @(posedge aclk) begin
      if (!aresetn) begin
         acc_reg  <= 14'h0000;
         cpu_tick <= 1'b0;
         cpu_fast <= 1'b0;
      end else begin
         cpu_tick <= tick_now;
         if (tick_now) begin
            // switching only at a tick keeps every cycle whole
            cpu_fast <= speed_reg && !stretch;             // R14
         end
         // the remainder is kept at a tick; dropping it would slow
         // the standard rate to a third of aclk
         if (cpu_fast)
            acc_reg <= 14'h0000;
         else if (tick_now)
            acc_reg <= acc_left[13:0];                     // R01
         else
            acc_reg <= acc_sum[13:0];                      // R01
      end
   end

   // access cycle counting
   always @(posedge aclk) begin
      if (!aresetn) begin
         bus_busy <= 1'b0;
         bus_done <= 1'b0;
         kind_reg <= `CSPF_K_MEM;
         tcnt_reg <= 3'd0;
      end else begin
         bus_done <= 1'b0;
         if (!bus_busy) begin
            if (bus_start) begin
               bus_busy <= 1'b1;
               kind_reg <= bus_kind;
               tcnt_reg <= 3'd0;
            end
         end else if (tick_now && rate_ok) begin
            if (tcnt_reg == need_cyc - 3'd1) begin
               // stretch drops here, rate returns next tick
               bus_busy <= 1'b0;                           // R14
               bus_done <= 1'b1;                           // R02 R03
            end else begin
               tcnt_reg <= tcnt_reg + 3'd1;
            end
         end
      end
   end

   // ------------------------------------------------
   // front panel
   // ------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         speed_lamp   <= 1'b0;
         hdd_lamp     <= 1'b0;
         seg_tens     <= `CSPF_SEG_BLANK;
         seg_units    <= `CSPF_SEG_5;
         sys_reset    <= 1'b0;
         kb_out_valid <= 1'b0;
         kb_out_data  <= 8'h00;
      end else begin
         speed_lamp <= speed_reg;                          // R07
         hdd_lamp   <= hdd_act_s;                          // R12
         if (speed_reg) begin
            seg_tens  <= `CSPF_SEG_1;                      // R08
            seg_units <= `CSPF_SEG_0;                      // R08
         end else begin
            seg_tens  <= `CSPF_SEG_BLANK;                  // R08
            seg_units <= `CSPF_SEG_5;                      // R08
         end
         sys_reset    <= rst_btn_s && !rst_locked;         // R11 R10
         kb_out_valid <= kb_valid && !kb_locked;           // R09
         if (kb_valid && !kb_locked)
            kb_out_data <= kb_data;                        // R09
      end
   end

   // ------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------
   // address and data are caught separately in either order
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;

   wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
   wire wr_hit  = (aw_addr_reg[11:2] == SPEED_IDX);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg  <= 1'b0;
         aw_addr_reg  <= 12'h000;
         w_full_reg   <= 1'b0;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CSPF_RESP_OKAY;
         speed_reg    <= `CSPF_SPEED_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit || aw_addr_reg[11:2] == STATUS_IDX) ?
                            `CSPF_RESP_OKAY : `CSPF_RESP_SLVERR;
            // only the low byte lane holds the speed bit
            if (wr_hit && w_strb_reg[0])
               speed_reg <= w_data_reg[`CSPF_SPEED_BIT];   // R13
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `CSPF_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `CSPF_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
         if (s_axi_araddr[11:2] == SPEED_IDX) begin
            // unused bits read as zero
            s_axi_rdata[`CSPF_SPEED_BIT] <= speed_reg;     // R13
         end else if (s_axi_araddr[11:2] == STATUS_IDX) begin
            s_axi_rdata[`CSPF_ST_FAST]    <= cpu_fast;
            s_axi_rdata[`CSPF_ST_STRETCH] <= stretch;
            s_axi_rdata[`CSPF_ST_KBLOCK]  <= kb_locked;
            s_axi_rdata[`CSPF_ST_RSTLOCK] <= rst_locked;
            s_axi_rdata[`CSPF_ST_BUSY]    <= bus_busy;
         end else begin
            s_axi_rresp <= `CSPF_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // cspf_top

// ===== design/cspf_map.vh
`ifndef CSPF_MAP_VH
`define CSPF_MAP_VH
// register byte addresses
`define CSPF_SPEED_ADDR  12'h1F0
`define CSPF_STATUS_ADDR 12'h1F4
// field positions
`define CSPF_SPEED_BIT   7
`define CSPF_ST_FAST     0
`define CSPF_ST_STRETCH  1
`define CSPF_ST_KBLOCK   2
`define CSPF_ST_RSTLOCK  3
`define CSPF_ST_BUSY     4
// reset values
`define CSPF_SPEED_RST   1'b0
// bus answers
`define CSPF_RESP_OKAY   2'b00
`define CSPF_RESP_SLVERR 2'b10
// clock rates in kHz
`define CSPF_CLK_KHZ     15'd10000
`define CSPF_STD_KHZ     15'd4770
`define CSPF_FAST_KHZ    15'd10000
// access times in ns
`define CSPF_MEM_STD_NS  840
`define CSPF_IO_NS       1050
`define CSPF_MEM_FAST_NS 400
// processor cycles per access
`define CSPF_MEM_CYC     3'd4
`define CSPF_IO_CYC      3'd5
`define CSPF_DMA_CYC     3'd4
// access kinds
`define CSPF_K_MEM       2'd0
`define CSPF_K_IO        2'd1
`define CSPF_K_DMA       2'd2
// seven-segment codes, gfedcba
`define CSPF_SEG_BLANK   7'h00
`define CSPF_SEG_0       7'h3F
`define CSPF_SEG_1       7'h06
`define CSPF_SEG_5       7'h6D
`endif

// ===== verif/cspf_chk.sv
`timescale 1ns/1ps
module cspf_chk (
   input wire       aclk,
   input wire       aresetn,
   input wire       bus_start,
   input wire [1:0] bus_kind,
   input wire       bus_busy,
   input wire       bus_done,
   input wire       cpu_fast,
   input wire       speed_lamp,
   input wire [6:0] seg_tens,
   input wire [6:0] seg_units,
   input wire       kb_valid,
   input wire       kb_out_valid,
   input wire       kb_lock_pin,
   input wire       sec_lock_right_pin,
   input wire       reset_btn_pin,
   input wire       sys_reset,
   input wire       hdd_act_pin,
   input wire       hdd_lamp
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [1:0] kind_reg;
   // kind of the access in flight, taken like the block takes it
   always @(posedge aclk)
      if (bus_start && !bus_busy) kind_reg <= bus_kind;
   done_pulse_a: assert property (bus_done |-> !bus_busy ##1 !bus_done)
      else $error("done not a lone pulse");
   done_bound_a: assert property (bus_start && !bus_busy |=> bus_busy ##[0:40] bus_done)
      else $error("access never completed");
   io_slow_a: assert property (bus_done && kind_reg inside {2'd1, 2'd2} |-> !cpu_fast)
      else $error("io or dma ended at fast rate");
   lamp_on_a: assert property ($rose(cpu_fast) |-> speed_lamp)
      else $error("fast rate with lamp dark");
   seg_code_a: assert property ((seg_tens == 7'h00 && seg_units == 7'h6D) ||
      (seg_tens == 7'h06 && seg_units == 7'h3F))
      else $error("bad display code");
   kb_drop_a: assert property (kb_lock_pin[*4] ##0 kb_valid |=> !kb_out_valid)
      else $error("key passed while locked");
   kb_sec_a: assert property (sec_lock_right_pin[*4] ##0 kb_valid |=> !kb_out_valid)
      else $error("key passed with security lock right");
   rst_lock_a: assert property (sec_lock_right_pin[*5] |-> !sys_reset)
      else $error("reset while locked");
   rst_press_a: assert property ((reset_btn_pin && !sec_lock_right_pin)[*5] |-> sys_reset)
      else $error("reset button ignored");
   hdd_lamp_a: assert property (hdd_act_pin[*4] |-> hdd_lamp)
      else $error("disk lamp dark");
   io_fast_c: cover property (bus_done && kind_reg == 2'd1 && speed_lamp);
   kb_pass_c: cover property (kb_out_valid);
   sys_rst_c: cover property (sys_reset);
endmodule // cspf_chk
bind cspf_top cspf_chk cspf_chk_i (.*);

// ===== verif/cspf_cpu_model.sv
`timescale 1ns/1ps
// processor side: offers one access, holds it until the block takes it
module cspf_cpu_model (
   input  wire       aclk,
   input  wire       req,
   input  wire [1:0] req_kind,
   input  wire       bus_busy,
   output reg        bus_start,
   output reg  [1:0] bus_kind
);
   initial bus_start = 1'b0;
   initial bus_kind = 2'b11;
   // kind lines show junk once taken, so a stale value cannot pass
   always @(posedge aclk)
      if (bus_start && !bus_busy) begin
         bus_start <= 1'b0;
         bus_kind <= ~bus_kind;
      end else if (req && !bus_start) begin
         bus_start <= 1'b1;
         bus_kind <= req_kind;
      end
endmodule // cspf_cpu_model

// ===== verif/test_cpu_speed_front_panel.sv
`timescale 1ns/1ps
`include "cspf_map.vh"
module test_cpu_speed_front_panel;
   reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   reg         s_axi_rready, req, kb_valid, kb_lock_pin, sec_lock_right_pin;
   reg         reset_btn_pin, hdd_act_pin;
   reg  [11:0] s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata;
   reg  [3:0]  s_axi_wstrb;
   reg  [1:0]  req_kind;
   reg  [7:0]  kb_data;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp, bus_kind;
   wire [31:0] s_axi_rdata;
   wire        bus_start, bus_busy, bus_done, cpu_tick, cpu_fast, kb_out_valid;
   wire        sys_reset, speed_lamp, hdd_lamp;
   wire [7:0]  kb_out_data;
   wire [6:0]  seg_tens, seg_units;
   integer     n_errors, check_count;
   cspf_top cspf_top_i (.*);
   cspf_cpu_model cspf_cpu_model_i (.*);
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one register access; ready and the answer are taken at the rising edge itself
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, ed,
                      input logic [1:0] er);
      logic ta, tw, tr;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      do begin
         @(posedge aclk);
         ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_bready && s_axi_bvalid || s_axi_rready && s_axi_rvalid;
         if (tr) chk(w ? s_axi_bresp : s_axi_rresp, er);
         if (tr && !w) chk(s_axi_rdata, ed);
         if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) {s_axi_bready, s_axi_rready} <= 2'b00;
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_arvalid || s_axi_bready || s_axi_rready);
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_panel(input logic f);
      integer c;
      c = 0;
      repeat (100) begin
         @(negedge aclk);
         if (cpu_tick) c = c + 1;
      end
      chk(f ? c == 100 : c inside {47, 48}, 1'b1);
      chk(speed_lamp, f);
      chk({seg_tens, seg_units}, f ? 14'h033F : 14'h006D);
   endtask
   task automatic t_acc(input logic [1:0] k, input integer lo, hi, input logic f);
      integer n;
      @(posedge aclk);
      req <= 1'b1;
      req_kind <= k;
      @(posedge aclk);
      req <= 1'b0;
      n = 0;
      do begin
         @(negedge aclk);
         n = n + 1;
      end while (!bus_done && n < 60);
      chk(n >= lo && n <= hi, 1'b1);
      chk(cpu_fast, k == 2'd0 ? f : 1'b0);
      repeat (4) @(negedge aclk);
      chk(cpu_fast, f);
   endtask
   task automatic kb(input logic [7:0] d, input logic e);
      @(posedge aclk);
      kb_valid <= 1'b1;
      kb_data <= d;
      @(posedge aclk);
      kb_valid <= 1'b0;
      @(negedge aclk);
      chk(kb_out_valid, e);
      if (e) chk(kb_out_data, d);
   endtask
   task t_lock;
      kb(8'hA5, 1'b1);
      @(posedge aclk);
      kb_lock_pin <= 1'b1;
      repeat (4) @(negedge aclk);
      kb(8'h5A, 1'b0);
      @(posedge aclk);
      {kb_lock_pin, sec_lock_right_pin, reset_btn_pin} <= 3'b011;
      repeat (6) @(negedge aclk);
      chk(sys_reset, 1'b0);
      kb(8'h3C, 1'b0);
      @(posedge aclk);
      {kb_lock_pin, sec_lock_right_pin, hdd_act_pin} <= 3'b001;
      repeat (6) @(negedge aclk);
      chk({sys_reset, hdd_lamp}, 2'b11);
      @(posedge aclk);
      {reset_btn_pin, hdd_act_pin} <= 2'b00;
      repeat (6) @(negedge aclk);
      chk({sys_reset, hdd_lamp}, 2'b00);
   endtask
   task complete_run;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // the run needs about 400 cycles, so 10000 means a hang
   initial begin
      #1000000;
      n_errors = n_errors + 1;
      complete_run;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {req, kb_valid, kb_lock_pin, sec_lock_right_pin, reset_btn_pin, hdd_act_pin} = 0;
      {req_kind, kb_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hF;
      n_errors = 0;
      check_count = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_panel(1'b0);
      t_acc(2'd0, 8, 14, 1'b0);
      t_acc(2'd1, 10, 17, 1'b0);
      acc(1'b0, `CSPF_SPEED_ADDR, 0, 32'h0, 2'b00);
      acc(1'b1, `CSPF_SPEED_ADDR, 32'hFFFFFF7F, 0, 2'b00);
      acc(1'b0, `CSPF_SPEED_ADDR, 0, 32'h0, 2'b00);
      acc(1'b1, `CSPF_SPEED_ADDR, 32'h00000080, 0, 2'b00);
      acc(1'b0, 12'h100, 0, 32'h0, 2'b10);
      acc(1'b1, `CSPF_STATUS_ADDR, 32'h0, 0, 2'b00);
      acc(1'b0, `CSPF_SPEED_ADDR, 0, 32'h00000080, 2'b00);
      t_panel(1'b1);
      acc(1'b0, `CSPF_STATUS_ADDR, 0, 32'h00000001, 2'b00);
      t_acc(2'd0, 4, 7, 1'b1);
      t_acc(2'd1, 10, 20, 1'b1);
      t_acc(2'd2, 8, 17, 1'b1);
      t_lock;
      complete_run;
   end
endmodule // test_cpu_speed_front_panel
